// ==== rtl/sadc_clk_div.sv ====
`default_nettype none
module sadc_clk_div
  import sadc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic divide_select_low_i,
  input wire logic divide_select_high_i,
  sadc_tick_if.src tick
);
  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  wire logic [1:0] sel = {divide_select_high_i, divide_select_low_i};
  sadc_div_t mode;
  logic [1:0] term;
  logic [1:0] cnt_reg;
  logic en_reg;
  wire logic pd = (mode == DIV_OFF);

  always_comb begin
    case (sel)
      SEL_DIV1: mode = DIV_1;
      SEL_DIV2: mode = DIV_2;
      SEL_DIV3: mode = DIV_3;
      default: mode = DIV_OFF;
    endcase
  end

  always_comb begin
    case (mode)
      DIV_1: term = TERM_DIV1;
      DIV_2: term = TERM_DIV2;
      DIV_3: term = TERM_DIV3;
      default: term = TERM_DIV1;
    endcase
  end

  // ------------------------------------------------------------
  // Sample-clock enable
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i || pd) begin
      cnt_reg <= CNT_ZERO;
      en_reg <= 1'b0;
    end else if (cnt_reg >= term) begin
      cnt_reg <= CNT_ZERO;
      en_reg <= 1'b1;
    end else begin
      cnt_reg <= 2'(cnt_reg + CNT_ONE);
      en_reg <= 1'b0;
    end
  end

  assign tick.sample_en = en_reg;
  assign tick.power_down = pd;

  chk_div_three_gap: assert property (@(posedge clock_i) disable iff (reset_i)
    (en_reg && mode == DIV_3 && $stable(sel)) ##1 (mode == DIV_3)[*3]
      |-> !$past(en_reg, 1) && !$past(en_reg, 2) && en_reg)
    else $error("divide by three enable spacing wrong");
  chk_div_one_run: assert property (@(posedge clock_i) disable iff (reset_i)
    (mode == DIV_1)[*3] |-> en_reg)
    else $error("divide by one enable not continuous");
  chk_pd_silent: assert property (@(posedge clock_i) disable iff (reset_i)
    pd |=> !en_reg)
    else $error("sample enable in power down");
endmodule
`default_nettype wire

// ==== rtl/sadc_pkg.sv ====
`default_nettype none
package sadc_pkg;
  // ------------------------------------------------------------
  // Divide-select pin codes {high, low}
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_DIV1 = 2'h1;
  localparam logic [1:0] SEL_DIV2 = 2'h2;
  localparam logic [1:0] SEL_DIV3 = 2'h3;
  // Divider terminal counts (ratio minus one)
  localparam logic [1:0] TERM_DIV1 = 2'h0;
  localparam logic [1:0] TERM_DIV2 = 2'h1;
  localparam logic [1:0] TERM_DIV3 = 2'h2;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;

  // ------------------------------------------------------------
  // Frame and word layout
  // ------------------------------------------------------------
  localparam int TICK_W = 7;
  localparam logic [6:0] TICK_ZERO = 7'h00;
  localparam logic [6:0] TICK_ONE = 7'h01;
  localparam logic [6:0] FRAME_LAST = 7'h7f;
  localparam logic [5:0] BIT_ONE = 6'h01;
  localparam int WORD_W = 16;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] POS_ONE = 5'h01;

  // ------------------------------------------------------------
  // Filter latency in frames
  // ------------------------------------------------------------
  localparam logic [5:0] GROUP_DELAY_FRAMES = 6'h21;
  localparam logic [5:0] SETTLE_FRAMES = 6'h31;
  localparam logic [5:0] FRAMES_ONE = 6'h01;

  typedef enum logic [3:0] {
    DIV_OFF = 4'b0001,
    DIV_1 = 4'b0010,
    DIV_2 = 4'b0100,
    DIV_3 = 4'b1000
  } sadc_div_t;
endpackage
`default_nettype wire

// ==== rtl/sadc_serial_out.sv ====
`default_nettype none
// How it works
// - Master clock divided by one, two, three
// - Divide pins: off, by1, by2, by3
// - One sample pair every 128 sample ticks
// - Frame strobe period is 128 ticks
// - Strobe and bit clock direction follow mode
// - Low drives both pins, high receives them
// - Strobe edge resynchronises transmitter and counters
// - Left while strobe high, right while low
// - Data changes on bit clock rising edge
// - Slave bit clock resampled by sample clock
// - MSB first, left word before right
// - Between words float or drive low
// - Strobe early by one bit or coincident
// - Group delay 33, settling 49 frames
module sadc_serial_out
  import sadc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic divide_select_low_i,
  input wire logic divide_select_high_i,
  input wire logic master_slave_select_i,
  input wire logic strobe_format_select_i,
  input wire logic output_drive_select_i,
  input wire logic [WORD_W-1:0] left_word_i,
  input wire logic [WORD_W-1:0] right_word_i,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_n_o,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic word_load_o,
  output logic data_valid_o,
  output logic settled_o
);
  sadc_tick_if tick ();

  sadc_clk_div u_div (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .divide_select_low_i(divide_select_low_i),
    .divide_select_high_i(divide_select_high_i),
    .tick(tick)
  );

  logic [TICK_W-1:0] tick_reg;
  logic sclk_q;
  logic sync_q;
  logic sy1_reg;
  logic sy2_reg;
  logic [4:0] pos_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] right_hold_reg;
  logic sdo_reg;
  logic sdo_oe_n_reg;
  logic pin_oe_n_reg;
  logic load_reg;
  logic [5:0] frames_reg;
  logic valid_reg;
  logic settled_reg;

  // ------------------------------------------------------------
  // Master timing and pin selection
  // ------------------------------------------------------------
  wire logic en = tick.sample_en;
  wire logic pd = tick.power_down;
  wire logic slave = master_slave_select_i;
  wire logic fmt = strobe_format_select_i;
  wire logic [TICK_W-1:0] tick_next = 7'(tick_reg + TICK_ONE);
  wire logic [5:0] bidx = tick_next[6:1];
  wire logic [5:0] bidx_early = 6'(bidx + BIT_ONE);
  wire logic m_sclk = ~tick_next[0];
  wire logic m_sync = fmt ? ~bidx[5] : ~bidx_early[5];
  wire logic sclk_smp = slave ? sclk_i : m_sclk;
  wire logic sync_smp = slave ? sync_i : m_sync;
  wire logic bit_rise = en & sclk_smp & ~sclk_q;
  wire logic sync_rise = en & sync_smp & ~sync_q;
  wire logic frame_evt = slave ? sync_rise : (en & (tick_next == TICK_ZERO));

  // ------------------------------------------------------------
  // Word boundaries
  // ------------------------------------------------------------
  wire logic left_start = fmt ? (sync_smp & ~sy1_reg) : (sy1_reg & ~sy2_reg);
  wire logic right_start = fmt ? (~sync_smp & sy1_reg) : (~sy1_reg & sy2_reg);
  wire logic any_start = left_start | right_start;
  wire logic [WORD_W-1:0] start_word = left_start ? left_word_i : right_hold_reg;
  wire logic in_word = pos_reg < WORD_BITS;

  always_ff @(posedge clock_i) begin
    if (reset_i || pd) begin
      tick_reg <= TICK_ZERO;
      sclk_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (slave && frame_evt) begin
      tick_reg <= TICK_ZERO;
      sclk_q <= sclk_smp;
      sync_q <= sync_smp;
    end else if (en) begin
      tick_reg <= tick_next;
      sclk_q <= sclk_smp;
      sync_q <= sync_smp;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_oe_n_reg <= slave;
    end
  end

  // ------------------------------------------------------------
  // Serial transmitter
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i || pd) begin
      sy1_reg <= 1'b0;
      sy2_reg <= 1'b0;
      pos_reg <= WORD_BITS;
      shift_reg <= '0;
      right_hold_reg <= '0;
      sdo_reg <= 1'b0;
      sdo_oe_n_reg <= 1'b1;
      load_reg <= 1'b0;
    end else begin
      load_reg <= bit_rise & left_start;
      if (bit_rise) begin
        sy1_reg <= sync_smp;
        sy2_reg <= sy1_reg;
        if (left_start) begin
          right_hold_reg <= right_word_i;
        end
        if (any_start) begin
          pos_reg <= POS_ONE;
          sdo_reg <= start_word[WORD_W-1];
          shift_reg <= {start_word[WORD_W-2:0], 1'b0};
          sdo_oe_n_reg <= 1'b0;
        end else if (in_word) begin
          pos_reg <= 5'(pos_reg + POS_ONE);
          sdo_reg <= shift_reg[WORD_W-1];
          shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
          sdo_oe_n_reg <= 1'b0;
        end else begin
          sdo_reg <= 1'b0;
          sdo_oe_n_reg <= ~output_drive_select_i;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Filter latency tracking
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i || pd) begin
      frames_reg <= '0;
      valid_reg <= 1'b0;
      settled_reg <= 1'b0;
    end else begin
      if (frame_evt && frames_reg < SETTLE_FRAMES) begin
        frames_reg <= 6'(frames_reg + FRAMES_ONE);
      end
      valid_reg <= frames_reg >= GROUP_DELAY_FRAMES;
      settled_reg <= frames_reg >= SETTLE_FRAMES;
    end
  end

  assign sclk_o = sclk_q;
  assign sync_o = sync_q;
  assign sclk_oe_n_o = pin_oe_n_reg;
  assign sync_oe_n_o = pin_oe_n_reg;
  assign sdo_o = sdo_reg;
  assign sdo_oe_n_o = sdo_oe_n_reg;
  assign word_load_o = load_reg;
  assign data_valid_o = valid_reg;
  assign settled_o = settled_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [TICK_W-1:0] en_since_reg;
  always_ff @(posedge clock_i) begin
    if (reset_i || pd || frame_evt) begin
      en_since_reg <= TICK_ZERO;
    end else if (en) begin
      en_since_reg <= 7'(en_since_reg + TICK_ONE);
    end
  end

  chk_frame_ticks: assert property (@(posedge clock_i) disable iff (reset_i || pd)
    (frame_evt && !slave && $stable(slave)) |-> en_since_reg == FRAME_LAST)
    else $error("master frame is not 128 sample ticks");
  chk_pin_dir: assert property (@(posedge clock_i) disable iff (reset_i)
    ##1 (sclk_oe_n_o == $past(slave || reset_i)) && (sync_oe_n_o == $past(slave || reset_i)))
    else $error("strobe or bit clock direction wrong");
  chk_msb_first: assert property (@(posedge clock_i) disable iff (reset_i || pd)
    (bit_rise && left_start) |=> sdo_o == $past(left_word_i[WORD_W-1]) && !sdo_oe_n_o)
    else $error("left word msb not sent first");
  chk_idle_drive: assert property (@(posedge clock_i) disable iff (reset_i || pd)
    (bit_rise && !any_start && !in_word)
      |=> !sdo_o && sdo_oe_n_o == !$past(output_drive_select_i))
    else $error("idle data pin state wrong");
  chk_rise_update: assert property (@(posedge clock_i) disable iff (reset_i || pd)
    $changed(sdo_o) |-> $past(bit_rise))
    else $error("data changed away from bit clock rise");
  chk_slave_resample: assert property (@(posedge clock_i) disable iff (reset_i || pd)
    (slave && !en) |=> $stable(sclk_q))
    else $error("slave bit clock sampled off the sample tick");
  chk_frame_resync: assert property (@(posedge clock_i) disable iff (reset_i || pd)
    (slave && sync_rise) |=> tick_reg == TICK_ZERO)
    else $error("strobe did not resynchronise frame counter");
  chk_right_low: assert property (@(posedge clock_i) disable iff (reset_i || pd)
    (bit_rise && right_start) |=> !sync_o && !sdo_oe_n_o)
    else $error("right word started while strobe high");
  chk_settle_time: assert property (@(posedge clock_i) disable iff (reset_i || pd)
    $rose(settled_o) |-> $past(frames_reg) == SETTLE_FRAMES && data_valid_o)
    else $error("settled flag timing wrong");
endmodule
`default_nettype wire

// ==== rtl/sadc_tick_if.sv ====
`default_nettype none
interface sadc_tick_if;
  logic sample_en;
  logic power_down;
  modport src (output sample_en, output power_down);
  modport dst (input sample_en, input power_down);
endinterface
`default_nettype wire

// ==== test/sadc_dsp_model.sv ====
`default_nettype none
module sadc_dsp_model (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic drive_i,
  input wire logic early_i,
  input wire logic sclk_w_i,
  input wire logic sync_w_i,
  input wire logic sdo_w_i,
  output logic sclk_o,
  output logic sync_o,
  output logic [15:0] left_o,
  output logic [15:0] right_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt_reg;
  logic sclk_d_reg;
  logic sync_f_reg;
  logic [4:0] nbits_reg;
  logic [15:0] shift_reg;
  wire fall = sclk_d_reg & ~sclk_w_i;
  wire [15:0] shifted = {shift_reg[14:0], sdo_w_i};
  // ----------------------------------------
  // Frame source for slave mode
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    cnt_reg <= (reset_i | ~drive_i) ? 7'h00 : cnt_reg + 7'h01;
  end
  assign sclk_o = ~cnt_reg[0];
  assign sync_o = ~cnt_reg[6];
  // ----------------------------------------
  // Receiver, data taken on falling bit clock
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    sclk_d_reg <= sclk_w_i;
    if (reset_i) begin
      sync_f_reg <= 1'b0;
      nbits_reg <= 5'h10;
    end else if (fall) begin
      sync_f_reg <= sync_w_i;
      shift_reg <= shifted;
      if (sync_w_i != sync_f_reg) begin
        nbits_reg <= {4'h0, ~early_i};
      end else if (nbits_reg != 5'h10) begin
        nbits_reg <= nbits_reg + 5'h01;
        if (nbits_reg == 5'h0f && sync_w_i) left_o <= shifted;
        if (nbits_reg == 5'h0f && !sync_w_i) right_o <= shifted;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/stereo_adc_serial_output_bench.sv ====
`default_nettype none
module stereo_adc_serial_output_bench;
  import sadc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] sel;
    logic f;
    logic d;
    logic [15:0] l;
    logic [15:0] r;
  } sadc_row_t;
  sadc_row_t rows [4] = '{'{2'h1, 1'b0, 1'b1, 16'ha5c3, 16'h3c5a},
    '{2'h2, 1'b1, 1'b0, 16'h8001, 16'h7ffe}, '{2'h3, 1'b0, 1'b0, 16'hffff, 16'h0000},
    '{2'h1, 1'b1, 1'b1, 16'h0001, 16'h8000}};
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic sel_lo = 1'b1;
  logic sel_hi = 1'b0;
  logic slave = 1'b0;
  logic fmt = 1'b1;
  logic drv = 1'b1;
  logic [15:0] lw = 16'h0000;
  logic [15:0] rw = 16'h0000;
  logic sclk_o, sclk_oe_n_o, sync_o, sync_oe_n_o, sdo_o, sdo_oe_n_o, valid, settled, load;
  logic p_sclk, p_sync;
  logic sync_d = 1'b0;
  logic sclk_d = 1'b0;
  logic cyc = 1'b0;
  logic [15:0] got_l, got_r;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int bits = 0;
  int loads = 0;
  // Released pins show a toggling pattern, never the last value; in slave mode clock and strobe carry the DSP model instead
  wire sclk_w = !sclk_oe_n_o ? sclk_o : (slave ? p_sclk : cyc);
  wire sync_w = !sync_oe_n_o ? sync_o : (slave ? p_sync : cyc);
  wire sdo_w = !sdo_oe_n_o ? sdo_o : cyc;

  always #12.5 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cyc <= ~cyc;
    sync_d <= sync_w;
    sclk_d <= sclk_w;
    if (sclk_w && !sclk_d) bits++;
    if (load) loads++;
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      conclude();
    end
  end

  sadc_serial_out i_dut (.clock_i(clock_i), .reset_i(reset_i), .divide_select_low_i(sel_lo),
    .divide_select_high_i(sel_hi), .master_slave_select_i(slave), .strobe_format_select_i(fmt),
    .output_drive_select_i(drv), .left_word_i(lw), .right_word_i(rw), .sclk_i(sclk_w),
    .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o), .sync_i(sync_w), .sync_o(sync_o),
    .sync_oe_n_o(sync_oe_n_o), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .word_load_o(load),
    .data_valid_o(valid), .settled_o(settled));

  sadc_dsp_model i_dsp (.clock_i(clock_i), .reset_i(reset_i), .drive_i(slave), .early_i(~fmt),
    .sclk_w_i(sclk_w), .sync_w_i(sync_w), .sdo_w_i(sdo_w), .sclk_o(p_sclk), .sync_o(p_sync),
    .left_o(got_l), .right_o(got_r));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic next_rise(output int n);
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (!(sync_w && !sync_d) && n < 1000);
  endtask

  task automatic setup(input logic [1:0] sel, input logic f, d, s, input logic [15:0] l, r);
    @(posedge clock_i);
    {sel_hi, sel_lo} <= sel;
    fmt <= f;
    drv <= d;
    slave <= s;
    lw <= l;
    rw <= r;
  endtask

  initial begin
    int n;
    repeat (7) @(posedge clock_i);
    @(negedge clock_i);
    check("oe in reset", {14'h0, sclk_oe_n_o, sdo_oe_n_o}, 16'h0003);
    check("flags in reset", {14'h0, valid, settled}, 16'h0000);
    @(posedge clock_i);
    reset_i <= 1'b0;
    // ----------------------------------------
    // Master mode table
    // ----------------------------------------
    foreach (rows[i]) begin
      setup(rows[i].sel, rows[i].f, rows[i].d, 1'b0, rows[i].l, rows[i].r);
      repeat (3) next_rise(n);
      bits = 0;
      loads = 0;
      next_rise(n);
      check("frame clocks", n[15:0], 16'(128 * rows[i].sel));
      check("bit clocks", bits[15:0], 16'h0040);
      check("word loads", loads[15:0], 16'h0001);
      check("left word", got_l, rows[i].l);
      check("right word", got_r, rows[i].r);
      check("pin dir", {14'h0, sclk_oe_n_o, sync_oe_n_o}, 16'h0000);
      check("first bit", {14'h0, sdo_oe_n_o, sdo_o & ~sdo_oe_n_o},
        rows[i].f ? {15'h0, rows[i].l[15]} : {14'h0, ~rows[i].d, 1'b0});
      repeat (40 * rows[i].sel) @(negedge clock_i);
      check("idle pin", {14'h0, sdo_oe_n_o, sdo_o & ~sdo_oe_n_o},
        {14'h0, ~rows[i].d, 1'b0});
    end
    // ----------------------------------------
    // Slave mode, power down, filter flags
    // ----------------------------------------
    setup(2'h1, 1'b1, 1'b0, 1'b1, 16'hc3a5, 16'h5a3c);
    repeat (3) next_rise(n);
    check("slave dir", {14'h0, sclk_oe_n_o, sync_oe_n_o}, 16'h0003);
    n = 0;
    while (sdo_oe_n_o !== 1'b0 && n < 4) begin
      @(negedge clock_i);
      n++;
    end
    check("slave msb", {15'h0, sdo_o}, 16'h0001);
    check("slave left", got_l, 16'hc3a5);
    check("slave right", got_r, 16'h5a3c);
    setup(2'h0, 1'b1, 1'b0, 1'b0, 16'h1234, 16'h4321);
    repeat (4) @(negedge clock_i);
    next_rise(n);
    check("power down", {15'h0, n == 1000}, 16'h0001);
    check("flags off", {14'h0, valid, settled}, 16'h0000);
    setup(2'h1, 1'b1, 1'b1, 1'b0, 16'h1234, 16'h4321);
    repeat (31) next_rise(n);
    check("valid early", {15'h0, valid}, 16'h0000);
    repeat (4) next_rise(n);
    check("valid late", {15'h0, valid}, 16'h0001);
    repeat (12) next_rise(n);
    check("settle early", {15'h0, settled}, 16'h0000);
    repeat (4) next_rise(n);
    check("settle late", {15'h0, settled}, 16'h0001);
    conclude();
  end
endmodule
`default_nettype wire
